//--- uart_status_autobaud.v
// Serial port core: line status, scratch byte, auto-baud, receive queue
`default_nettype none
`include "uart_status_consts.vh"
module uart_status_autobaud #(
  parameter [15:0] ABAUD_TIMEOUT = `ABAUD_TIMEOUT
) (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  input wire serial_rx_in,
  output wire serial_tx_out,
  output wire tx_hold_empty_irq
);
  localparam AB_IDLE = 4'b0001;
  localparam AB_ARM = 4'b0010;
  localparam AB_MEAS = 4'b0100;
  localparam AB_GAP = 4'b1000;

  // Address match, shared by read mux and write strobes
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  reg [2:0] sync_q;
  reg rx_line_q;
  reg rx_prev_q;
  reg [7:0] div_q;
  reg irq_en_q;
  reg queue_enable;
  reg [2:0] lfmt_q;
  reg [7:0] scratch_q;
  reg mode_q;
  reg rearm_q;
  reg [3:0] ab_st_q;
  reg [15:0] ab_cnt_q;
  reg [15:0] ab_res_q;
  reg baud_done_flag;
  reg baud_timeout_flag;
  reg [3:0] err_q;
  reg [4:0] qcnt_q;
  reg [3:0] wp_q;
  reg [3:0] rp_q;
  reg head_new_q;
  reg [31:0] rd_mux;

  wire rx_valid;
  wire [7:0] rx_data;
  wire rx_pe;
  wire rx_fe;
  wire rx_brk;
  wire tx_hold_empty_flag;
  wire temt;
  wire [`RXQ_DEPTH*11-1:0] mem_flat;

  // Zero-wait slave: read data is captured in setup, effects land in access
  wire setup = psel & ~penable;
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  assign pready = 1'b1;
  wire mapped = hit(paddr, `OFS_DATA) | hit(paddr, `OFS_IRQEN) |
                hit(paddr, `OFS_QCTRL) | hit(paddr, `OFS_LFMT) |
                hit(paddr, `OFS_LSTAT) | hit(paddr, `OFS_SCRATCH) |
                hit(paddr, `OFS_ABCTRL) | hit(paddr, `OFS_ABSTAT);
  wire ab_wr = wr & hit(paddr, `OFS_ABCTRL);

  // Line synchroniser: a change counts once stages two and three agree
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_q <= 3'h7;
      rx_line_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      sync_q <= {sync_q[1:0], serial_rx_in};
      if (sync_q[1] == sync_q[2])
        rx_line_q <= sync_q[2];
      rx_prev_q <= rx_line_q;
    end
  end
  wire rx_fall = rx_prev_q & ~rx_line_q;
  wire rx_rise = ~rx_prev_q & rx_line_q;

  // Oversample enable, sixteen per bit time at a fixed divisor
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      div_q <= 8'h00;
    else if (div_q == `TICK_LAST)
      div_q <= 8'h00;
    else
      div_q <= div_q + 8'h01;
  end
  wire tick16 = (div_q == `TICK_LAST);

  uart_rx_frame u_rx (
    .clk(clk),
    .rst_n(rst_n),
    .tick16(tick16),
    .rx_line(rx_line_q),
    .parity_en(lfmt_q[0]),
    .parity_sel(lfmt_q[2:1]),
    .char_valid(rx_valid),
    .char_data(rx_data),
    .char_pe(rx_pe),
    .char_fe(rx_fe),
    .char_brk(rx_brk)
  );

  uart_tx_frame u_tx (
    .clk(clk),
    .rst_n(rst_n),
    .tick16(tick16),
    .hold_wr(wr & hit(paddr, `OFS_DATA)),
    .hold_data(pwdata[7:0]),
    .parity_en(lfmt_q[0]),
    .parity_sel(lfmt_q[2:1]),
    .serial_tx_out(serial_tx_out),
    .hold_empty(tx_hold_empty_flag),
    .tx_empty(temt)
  );

  assign tx_hold_empty_irq = tx_hold_empty_flag & irq_en_q;

  // Receive queue bookkeeping; a full queue drops the new character
  wire q_empty = (qcnt_q == 5'h00);
  wire q_full = (qcnt_q == `RXQ_DEPTH);
  wire push = rx_valid & ~q_full;
  wire overrun = rx_valid & q_full;
  wire pop = rd & hit(paddr, `OFS_DATA) & ~q_empty;
  wire [10:0] head = mem_flat[rp_q*11 +: 11];

  genvar gi;
  generate
    for (gi = 0; gi < `RXQ_DEPTH; gi = gi + 1) begin : g_ent
      reg [10:0] ent_q;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
          ent_q <= 11'h000;
        else if (push && wp_q == gi)
          ent_q <= {rx_brk, rx_fe, rx_pe, rx_data};
      end
      assign mem_flat[gi*11 +: 11] = ent_q;
    end
  endgenerate

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      qcnt_q <= 5'h00;
      wp_q <= 4'h0;
      rp_q <= 4'h0;
      head_new_q <= 1'b0;
    end else begin
      if (push)
        wp_q <= wp_q + 4'h1;
      if (pop)
        rp_q <= rp_q + 4'h1;
      if (push && !pop)
        qcnt_q <= qcnt_q + 5'h01;
      else if (pop && !push)
        qcnt_q <= qcnt_q - 5'h01;
      // A new character reaches the head: into an empty queue or after a pop
      head_new_q <= (push & q_empty) | (pop & ((qcnt_q != 5'h01) | push));
    end
  end

  // Error flags: queued mode reports char errors at head arrival, else at completion; overrun always at completion
  wire [2:0] head_err = head_new_q ? head[10:8] : 3'h0;
  wire [2:0] raw_err = rx_valid ? {rx_brk, rx_fe, rx_pe} : 3'h0;
  wire [3:0] err_set = {queue_enable ? head_err : raw_err, overrun};
  // Only bits software actually saw are cleared, so a fresh set survives
  wire ls_rd = rd & hit(paddr, `OFS_LSTAT);
  wire [3:0] err_clr = ls_rd ? prdata[`LS_BREAK:`LS_OE] : 4'h0;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      err_q <= 4'h0;
    else
      err_q <= (err_q & ~err_clr) | err_set;
  end

  // Software-written configuration
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_q <= 1'b0;
      queue_enable <= `QEN_RESET;
      lfmt_q <= 3'h0;
      scratch_q <= 8'h00;
      {rearm_q, mode_q} <= 2'h0;
    end else if (wr) begin
      if (hit(paddr, `OFS_IRQEN))
        irq_en_q <= pwdata[0];
      if (hit(paddr, `OFS_QCTRL))
        queue_enable <= pwdata[0];
      if (hit(paddr, `OFS_LFMT))
        lfmt_q <= pwdata[`LF_PSEL_HI:`LF_PAR_EN];
      if (hit(paddr, `OFS_SCRATCH))
        scratch_q <= pwdata[7:0];
      if (hit(paddr, `OFS_ABCTRL)) begin
        mode_q <= pwdata[`AB_MODE];
        rearm_q <= pwdata[`AB_REARM];
      end
    end
  end

  // Auto-baud measurement events
  wire ab_run = ~ab_st_q[0];
  wire ab_meas = ab_st_q[2] | ab_st_q[3];
  wire ab_end = (ab_st_q[2] & rx_rise & ~mode_q) | (ab_st_q[3] & rx_fall);
  wire ab_to = ab_meas & ~ab_end & (ab_cnt_q == ABAUD_TIMEOUT);

  // Measurement sequencer; mode 1 spans low then high up to next fall
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ab_st_q <= AB_IDLE;
      ab_cnt_q <= 16'h0000;
      ab_res_q <= 16'h0000;
    end else begin
      if (ab_meas)
        ab_cnt_q <= ab_cnt_q + 16'h0001;
      case (ab_st_q)
        AB_IDLE: begin
          if (ab_wr && pwdata[`AB_START])
            ab_st_q <= AB_ARM;
        end
        AB_ARM: begin
          ab_cnt_q <= 16'h0000;
          if (rx_fall)
            ab_st_q <= AB_MEAS;
        end
        AB_MEAS: begin
          if (rx_rise)
            ab_st_q <= mode_q ? AB_GAP : AB_IDLE;
        end
        AB_GAP: begin
          if (rx_fall)
            ab_st_q <= AB_IDLE;
        end
        default: ab_st_q <= AB_IDLE;
      endcase
      if (ab_end)
        ab_res_q <= ab_cnt_q + 16'h0001;
      if (ab_to)
        ab_st_q <= rearm_q ? AB_ARM : AB_IDLE;
      // Writing zero to the run bit aborts a measurement
      if (ab_wr && !pwdata[`AB_START] && ab_run)
        ab_st_q <= AB_IDLE;
    end
  end

  // Sticky auto-baud flags; a new event outranks a clear in the same cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      baud_done_flag <= 1'b0;
      baud_timeout_flag <= 1'b0;
    end else begin
      baud_done_flag <= ab_end |
        (baud_done_flag & ~(ab_wr & pwdata[`AB_DONE_CLR]));
      baud_timeout_flag <= ab_to |
        (baud_timeout_flag & ~(ab_wr & pwdata[`AB_TO_CLR]));
    end
  end

  // Read mux; clear bits of auto-baud control always read zero
  always @* begin
    rd_mux = 32'h00000000;
    if (hit(paddr, `OFS_DATA))
      rd_mux[7:0] = head[7:0];
    if (hit(paddr, `OFS_IRQEN))
      rd_mux[0] = irq_en_q;
    if (hit(paddr, `OFS_QCTRL))
      rd_mux[0] = queue_enable;
    if (hit(paddr, `OFS_LFMT))
      rd_mux[`LF_PSEL_HI:`LF_PAR_EN] = lfmt_q;
    if (hit(paddr, `OFS_LSTAT)) begin
      rd_mux[`LS_BREAK:`LS_OE] = err_q;
      rd_mux[`LS_RX_READY] = ~q_empty;
      rd_mux[`LS_HOLD_EMPTY] = tx_hold_empty_flag;
      rd_mux[`LS_TEMT] = temt;
    end
    if (hit(paddr, `OFS_SCRATCH))
      rd_mux[7:0] = scratch_q;
    if (hit(paddr, `OFS_ABCTRL))
      rd_mux[`AB_REARM:`AB_START] = {rearm_q, mode_q, ab_run};
    if (hit(paddr, `OFS_ABSTAT)) begin
      rd_mux[15:0] = ab_res_q;
      rd_mux[`ABS_DONE] = baud_done_flag;
      rd_mux[`ABS_TO] = baud_timeout_flag;
    end
  end

  // Answer is captured in setup and held through the access cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h00000000 : rd_mux;
      pslverr <= ~mapped;
    end
  end
endmodule // uart_status_autobaud
`default_nettype wire

//--- uart_status_consts.vh
// Offsets, field positions, reset values and timing counts of the serial port
`ifndef UART_STATUS_CONSTS_VH
`define UART_STATUS_CONSTS_VH
`define OFS_DATA 8'h00
`define OFS_IRQEN 8'h04
`define OFS_QCTRL 8'h08
`define OFS_LFMT 8'h0C
`define OFS_LSTAT 8'h14
`define OFS_SCRATCH 8'h1C
`define OFS_ABCTRL 8'h20
`define OFS_ABSTAT 8'h24
`define LS_RX_READY 0
`define LS_OE 1
`define LS_PARITY_ERR 2
`define LS_FRAMING_ERR 3
`define LS_BREAK 4
`define LS_HOLD_EMPTY 5
`define LS_TEMT 6
`define AB_START 0
`define AB_MODE 1
`define AB_REARM 2
`define AB_DONE_CLR 8
`define AB_TO_CLR 9
`define ABS_DONE 16
`define ABS_TO 17
`define LF_PAR_EN 3
`define LF_PSEL_LO 4
`define LF_PSEL_HI 5
`define PSEL_ODD 2'h0
`define PSEL_EVEN 2'h1
`define PSEL_ONE 2'h2
`define QEN_RESET 1'h1
`define ABCTRL_RESET 3'h0
`define TICK_LAST 8'h1A
`define MID_TICK 4'h7
`define LAST_TICK 4'hF
`define ABAUD_TIMEOUT 16'hFFFF
`define RXQ_DEPTH 16
`endif

//--- uart_rx_frame.v
// Receive framer: 16x oversampled 8-bit character with optional parity
`default_nettype none
`include "uart_status_consts.vh"
module uart_rx_frame (
  input wire clk,
  input wire rst_n,
  input wire tick16,
  input wire rx_line,
  input wire parity_en,
  input wire [1:0] parity_sel,
  output reg char_valid,
  output reg [7:0] char_data,
  output reg char_pe,
  output reg char_fe,
  output reg char_brk
);
  localparam S_IDLE = 6'b000001;
  localparam S_START = 6'b000010;
  localparam S_DATA = 6'b000100;
  localparam S_PAR = 6'b001000;
  localparam S_STOP = 6'b010000;
  localparam S_BRKW = 6'b100000;
  reg [5:0] st_q;
  reg [3:0] cnt_q;
  reg [2:0] bitn_q;
  reg [7:0] rx_shift_reg;
  reg par_q;
  reg allz_q;
  reg exp_par;
  // Expected parity bit for the held character
  always @* begin
    case (parity_sel)
      `PSEL_ODD: exp_par = ~^rx_shift_reg;
      `PSEL_EVEN: exp_par = ^rx_shift_reg;
      `PSEL_ONE: exp_par = 1'b1;
      default: exp_par = 1'b0;
    endcase
  end
  wire bit_end = tick16 & (cnt_q == `LAST_TICK);
  // Framing state machine; counter steps once per oversample tick
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_IDLE;
      cnt_q <= 4'h0;
      bitn_q <= 3'h0;
      rx_shift_reg <= 8'h00;
      par_q <= 1'b0;
      allz_q <= 1'b0;
      char_valid <= 1'b0;
      char_data <= 8'h00;
      char_pe <= 1'b0;
      char_fe <= 1'b0;
      char_brk <= 1'b0;
    end else begin
      char_valid <= 1'b0;
      if (tick16)
        cnt_q <= cnt_q + 4'h1;
      case (st_q)
        S_IDLE: begin
          cnt_q <= 4'h0;
          if (!rx_line)
            st_q <= S_START;
        end
        S_START: begin
          if (tick16 && cnt_q == `MID_TICK) begin
            cnt_q <= 4'h0;
            bitn_q <= 3'h0;
            allz_q <= 1'b1;
            st_q <= rx_line ? S_IDLE : S_DATA;
          end
        end
        S_DATA: begin
          if (bit_end) begin
            rx_shift_reg <= {rx_line, rx_shift_reg[7:1]};
            allz_q <= allz_q & ~rx_line;
            bitn_q <= bitn_q + 3'h1;
            if (bitn_q == 3'h7)
              st_q <= parity_en ? S_PAR : S_STOP;
          end
        end
        S_PAR: begin
          if (bit_end) begin
            par_q <= rx_line;
            allz_q <= allz_q & ~rx_line;
            st_q <= S_STOP;
          end
        end
        S_STOP: begin
          if (bit_end) begin
            char_valid <= 1'b1;
            char_data <= rx_shift_reg;
            char_pe <= parity_en & (par_q != exp_par);
            char_fe <= ~rx_line;
            char_brk <= allz_q & ~rx_line;
            cnt_q <= 4'h0;
            bitn_q <= 3'h0;
            allz_q <= 1'b1;
            if (allz_q && !rx_line)
              st_q <= S_BRKW;
            else if (!rx_line)
              st_q <= S_DATA;
            else
              st_q <= S_IDLE;
          end
        end
        S_BRKW: begin
          // Line must return to marking before a new start is hunted
          if (rx_line)
            st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule // uart_rx_frame
`default_nettype wire

//--- uart_tx_frame.v
// Transmit holding register and shift register with optional parity
`default_nettype none
`include "uart_status_consts.vh"
module uart_tx_frame (
  input wire clk,
  input wire rst_n,
  input wire tick16,
  input wire hold_wr,
  input wire [7:0] hold_data,
  input wire parity_en,
  input wire [1:0] parity_sel,
  output wire serial_tx_out,
  output wire hold_empty,
  output wire tx_empty
);
  reg [7:0] tx_holding_reg;
  reg full_q;
  reg [10:0] tx_shift_reg;
  reg [3:0] left_q;
  reg [3:0] cnt_q;
  reg par;
  always @* begin
    case (parity_sel)
      `PSEL_ODD: par = ~^tx_holding_reg;
      `PSEL_EVEN: par = ^tx_holding_reg;
      `PSEL_ONE: par = 1'b1;
      default: par = 1'b0;
    endcase
  end
  wire busy = (left_q != 4'h0);
  wire load = full_q & ~busy;
  // A write in the load cycle refills the holder, so no character is lost
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_holding_reg <= 8'h00;
      full_q <= 1'b0;
      tx_shift_reg <= 11'h7FF;
      left_q <= 4'h0;
      cnt_q <= 4'h0;
    end else begin
      if (hold_wr) begin
        tx_holding_reg <= hold_data;
        full_q <= 1'b1;
      end else if (load) begin
        full_q <= 1'b0;
      end
      if (load) begin
        tx_shift_reg <= parity_en ? {1'b1, par, tx_holding_reg, 1'b0}
                                  : {2'h3, tx_holding_reg, 1'b0};
        left_q <= parity_en ? 4'hB : 4'hA;
        cnt_q <= 4'h0;
      end else if (busy && tick16) begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == `LAST_TICK) begin
          tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
          left_q <= left_q - 4'h1;
        end
      end
    end
  end
  assign serial_tx_out = tx_shift_reg[0];
  assign hold_empty = ~full_q;
  assign tx_empty = ~full_q & ~busy;
endmodule // uart_tx_frame
`default_nettype wire

//--- uart_status_autobaud_props.sv
// Port-level assertions for the serial port status block
`default_nettype none
`include "uart_status_consts.vh"
module uart_status_autobaud_chk #(
  parameter [15:0] ABAUD_TIMEOUT = 16'hFFFF
) (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire serial_rx_in,
  input wire serial_tx_out,
  input wire tx_hold_empty_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic irq_en_q;
  logic ab_wr_q;
  logic [7:0] scr_q;
  logic [12:0] tx_quiet_q;
  // Bus decode; holes at 0x10 and 0x18 answer with an error
  wire acc = psel && penable && pready;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire wr_data = wr && paddr == `OFS_DATA;
  wire mapped = paddr[1:0] == 2'h0 && paddr <= 8'h24 && paddr != 8'h10 && paddr != 8'h18;
  // A full frame takes 4320 clocks, so a longer quiet line means no frame in flight
  wire tx_idle = tx_quiet_q > 13'h1130 && serial_tx_out;
  // Shadow copies of what software wrote
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_q <= 1'b0;
      ab_wr_q <= 1'b0;
      scr_q <= 8'h00;
      tx_quiet_q <= 13'h0000;
    end else begin
      if (wr && paddr == `OFS_IRQEN) irq_en_q <= pwdata[0];
      if (wr && paddr == `OFS_SCRATCH) scr_q <= pwdata[7:0];
      if (wr && paddr == `OFS_ABCTRL) ab_wr_q <= 1'b1;
      if (!serial_tx_out) tx_quiet_q <= 13'h0000;
      else if (tx_quiet_q != 13'h1FFF) tx_quiet_q <= tx_quiet_q + 13'h0001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Flag clears must not start a measurement, else completion could set them again
  sequence clr_done_s;
    wr && paddr == `OFS_ABCTRL && pwdata[`AB_DONE_CLR] && !pwdata[`AB_START];
  endsequence
  sequence clr_to_s;
    wr && paddr == `OFS_ABCTRL && pwdata[`AB_TO_CLR] && !pwdata[`AB_START];
  endsequence
  sequence rd_stat_s;
    rd && paddr == `OFS_ABSTAT;
  endsequence
  ready_high_a: assert property (pready) else $error("pready low");
  bad_addr_a: assert property (psel && !penable && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  hold_drop_a: assert property (wr_data && irq_en_q |=> !tx_hold_empty_irq)
    else $error("holding-empty did not drop on load");
  hold_refill_a: assert property (wr_data && irq_en_q && tx_idle
    |-> ##[2:4] tx_hold_empty_irq)
    else $error("holding-empty did not return");
  tx_start_a: assert property (wr_data && tx_idle |-> ##[2:60] !serial_tx_out)
    else $error("no start bit after load");
  irq_gate_a: assert property (!irq_en_q |-> !tx_hold_empty_irq)
    else $error("interrupt while disabled");
  scratch_keep_a: assert property (rd && paddr == `OFS_SCRATCH
    |-> prdata == {24'h000000, scr_q})
    else $error("scratch readback wrong");
  ab_reset_a: assert property (rd && paddr == `OFS_ABCTRL && !ab_wr_q |-> prdata == 32'h0)
    else $error("auto-baud control reset value wrong");
  done_clear_a: assert property (clr_done_s ##[2:4] rd_stat_s |-> !prdata[`ABS_DONE])
    else $error("done flag not cleared");
  to_clear_a: assert property (clr_to_s ##[2:4] rd_stat_s |-> !prdata[`ABS_TO])
    else $error("time-out flag not cleared");
endmodule // uart_status_autobaud_chk
bind uart_status_autobaud uart_status_autobaud_chk #(.ABAUD_TIMEOUT(ABAUD_TIMEOUT)) i_chk (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .serial_rx_in(serial_rx_in), .serial_tx_out(serial_tx_out),
  .tx_hold_empty_irq(tx_hold_empty_irq));
`default_nettype wire

//--- serial_peer.sv
// Remote serial end: frame sender on the receive line, byte catcher on transmit
`default_nettype none
module serial_peer #(
  parameter int BIT_CLKS = 432
) (
  input wire logic clk,
  input wire logic tx_line,
  output logic rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got;
  int n_got;
  // Idle line is marking
  initial rx_line = 1'b1;
  task automatic drive_bit(input logic b, input int n);
    rx_line <= b;
    repeat (n) @(posedge clk);
  endtask
  // Start, eight data bits LSB first, optional parity, one stop of chosen level
  task automatic send_char(input logic [7:0] d, input logic par_on, input logic par_v,
                           input logic stop_v);
    drive_bit(1'b0, BIT_CLKS);
    for (int i = 0; i < 8; i++) drive_bit(d[i], BIT_CLKS);
    if (par_on) drive_bit(par_v, BIT_CLKS);
    drive_bit(stop_v, BIT_CLKS);
    // Marking for one clock, so a following start never lands in the same step
    rx_line <= 1'b1;
    @(posedge clk);
  endtask
  // Mid-bit sampling of each transmitted frame
  initial begin
    n_got = 0;
    forever begin
      @(negedge tx_line);
      repeat (BIT_CLKS / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CLKS) @(posedge clk);
        got[i] = tx_line;
      end
      repeat (BIT_CLKS) @(posedge clk);
      n_got++;
    end
  end
endmodule // serial_peer
`default_nettype wire

//--- tb.sv
// Self-checking bench for the serial port status block
`default_nettype none
`include "uart_status_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 432;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  localparam logic [31:0] LOW5 = 32'h0000001F;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, rerr, rx, tx, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  int error_cnt, n_checks, cyc;
  uart_status_autobaud #(.ABAUD_TIMEOUT(16'h0064)) i_uart_status_autobaud (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .serial_rx_in(rx), .serial_tx_out(tx), .tx_hold_empty_irq(irq));
  serial_peer #(.BIT_CLKS(BIT)) i_serial_peer (.clk(clk), .tx_line(tx), .rx_line(rx));
  task automatic report_and_stop();
    if (error_cnt == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Masked word compare; unknown bits never match
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    n_checks++;
    if ((got & m) !== (exp & m)) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h mask %h", $time, got, exp, m);
    end
  endtask
  // One APB transfer; request held until pready is seen, idle cycle after
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h00000000);
    check(rdat, e, m);
  endtask
  task automatic low_pulse(input int lo, input int hi);
    i_serial_peer.drive_bit(1'b0, lo);
    i_serial_peer.drive_bit(1'b1, hi);
  endtask
  // Reset values, scratch byte, unmapped address
  task automatic t_regs();
    rd_chk(`OFS_LSTAT, 32'h00000060, ALL);
    rd_chk(`OFS_ABCTRL, 32'h00000000, ALL);
    apb(1'b1, `OFS_SCRATCH, 32'hFFFFFFA5);
    rd_chk(`OFS_SCRATCH, 32'h000000A5, ALL);
    rd_chk(`OFS_LSTAT, 32'h00000060, ALL);
    check({31'h0, irq}, 32'h00000000, ALL);
    rd_chk(8'h40, 32'h00000000, ALL);
    check({31'h0, rerr}, 32'h00000001, ALL);
  endtask
  // Both modes, time-out with and without rearm, write-one clears
  task automatic t_autobaud();
    // Long marking after each measurement's last pulse, so the receiver's mid-start sample sees high
    apb(1'b1, `OFS_ABCTRL, 32'h00000001);
    rd_chk(`OFS_ABCTRL, 32'h00000001, 32'h00000007);
    low_pulse(60, 300);
    rd_chk(`OFS_ABCTRL, 32'h00000000, 32'h00000001);
    rd_chk(`OFS_ABSTAT, 32'h00010000, 32'h00030000);
    apb(1'b1, `OFS_ABCTRL, 32'h00000100);
    rd_chk(`OFS_ABSTAT, 32'h00000000, 32'h00030000);
    apb(1'b1, `OFS_ABCTRL, 32'h00000003);
    low_pulse(30, 30);
    low_pulse(30, 300);
    rd_chk(`OFS_ABCTRL, 32'h00000002, 32'h00000003);
    rd_chk(`OFS_ABSTAT, 32'h00010000, 32'h00030000);
    apb(1'b1, `OFS_ABCTRL, 32'h00000101);
    low_pulse(150, 300);
    rd_chk(`OFS_ABSTAT, 32'h00020000, 32'h00020000);
    rd_chk(`OFS_ABCTRL, 32'h00000000, 32'h00000001);
    apb(1'b1, `OFS_ABCTRL, 32'h00000200);
    rd_chk(`OFS_ABSTAT, 32'h00000000, 32'h00030000);
    apb(1'b1, `OFS_ABCTRL, 32'h00000005);
    low_pulse(150, 300);
    rd_chk(`OFS_ABCTRL, 32'h00000005, 32'h00000005);
    low_pulse(60, 300);
    rd_chk(`OFS_ABSTAT, 32'h00030000, 32'h00030000);
    apb(1'b1, `OFS_ABCTRL, 32'h00000300);
    rd_chk(`OFS_ABSTAT, 32'h00000000, 32'h00030000);
  endtask
  // Even parity, wrong parity bit; then start a transmit that runs on
  task automatic t_parity();
    apb(1'b1, `OFS_LFMT, 32'h00000018);
    i_serial_peer.send_char(8'hA5, 1'b1, 1'b1, 1'b1);
    rd_chk(`OFS_LSTAT, 32'h00000005, LOW5);
    rd_chk(`OFS_LSTAT, 32'h00000001, LOW5);
    rd_chk(`OFS_DATA, 32'h000000A5, ALL);
    rd_chk(`OFS_LSTAT, 32'h00000000, LOW5);
    apb(1'b1, `OFS_LFMT, 32'h00000000);
    apb(1'b1, `OFS_IRQEN, 32'h00000001);
    check({31'h0, irq}, 32'h00000001, ALL);
    apb(1'b1, `OFS_DATA, 32'h0000003C);
  endtask
  // Zero stop bit, then resync on it as a start bit
  task automatic t_framing();
    i_serial_peer.send_char(8'h55, 1'b0, 1'b0, 1'b0);
    repeat (10 * BIT) @(posedge clk);
    rd_chk(`OFS_LSTAT, 32'h00000009, LOW5);
    rd_chk(`OFS_DATA, 32'h00000055, ALL);
    rd_chk(`OFS_LSTAT, 32'h00000001, LOW5);
    check({24'h0, i_serial_peer.got}, 32'h0000003C, ALL);
    check(32'(i_serial_peer.n_got), 32'h00000001, ALL);
    check({31'h0, irq}, 32'h00000001, ALL);
  endtask
  // Queue off: break behind the resync byte is flagged at completion; both bytes stay queued
  task automatic t_break();
    apb(1'b1, `OFS_QCTRL, 32'h00000000);
    low_pulse(12 * BIT, 2 * BIT);
    rd_chk(`OFS_LSTAT, 32'h00000011, 32'h00000017);
    rd_chk(`OFS_DATA, 32'h000000FF, ALL);
    rd_chk(`OFS_DATA, 32'h00000000, ALL);
    rd_chk(`OFS_LSTAT, 32'h00000000, LOW5);
    apb(1'b1, `OFS_QCTRL, 32'h00000001);
  endtask
  // Seventeen frames into a sixteen-deep queue
  task automatic t_overrun();
    for (int i = 0; i < 17; i++) i_serial_peer.send_char(8'(i), 1'b0, 1'b0, 1'b1);
    rd_chk(`OFS_LSTAT, 32'h00000003, LOW5);
    for (int i = 0; i < 16; i++) rd_chk(`OFS_DATA, 32'(i), ALL);
    rd_chk(`OFS_LSTAT, 32'h00000000, LOW5);
  endtask
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Run ceiling; the full sequence needs roughly 95200 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 99000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    error_cnt = 0;
    n_checks = 0;
    cyc = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_autobaud();
    t_parity();
    t_framing();
    t_break();
    t_overrun();
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
